// *** dv/qrt_aux_model.sv ***
// auxiliary winding and power switch as seen through the comparators
`timescale 1ns/10ps
`default_nettype none
module qrt_aux_model (
    // clock and switch gate
    input wire logic clk,
    input wire logic gate_on_r,
    // scenario controls
    input wire logic arm_en,
    input wire logic stuck_hi,
    input wire logic compare_hi,
    input wire logic [11:0] on_cyc,
    // comparator levels
    output logic demag_above_arm_level,
    output logic demag_above_trigger_level,
    output logic demag_above_compare_level,
    output logic peak_current_reached
);
    logic [15:0] t_r = 16'h0;
    logic gate_d_r = 1'b0;
    logic volt_hi;
    // time since the last gate edge
    always @(posedge clk) begin
        gate_d_r <= gate_on_r;
        t_r <= (gate_on_r != gate_d_r) ? 16'h0 : t_r + 16'h1;
    end
    // flat demag plateau for 300 cycles, then ringing of 64 cycles; no decay,
    // so a late valley is always available
    assign volt_hi = stuck_hi | (arm_en & !gate_on_r & (t_r < 16'd300 | t_r[5]));
    assign demag_above_arm_level = volt_hi;
    assign demag_above_trigger_level = volt_hi;
    assign demag_above_compare_level = volt_hi & compare_hi;
    assign peak_current_reached = gate_on_r & (t_r >= {4'h0, on_cyc});
endmodule // qrt_aux_model
`default_nettype wire

// *** dv/qrt_checker.sv ***
// port checker for the turn-on timing block
`timescale 1ns/10ps
`default_nettype none
`include "qrt_consts.vh"
module qrt_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // watched inputs
    input wire logic high_rate_variant,
    input wire logic supply_below_stop_level,
    input wire logic demag_above_compare_level,
    input wire logic peak_current_reached,
    // watched outputs
    input wire logic gate_on_r,
    input wire logic charge_enable_r,
    input wire logic sense_strobe_r,
    input wire logic blank_long_r,
    input wire logic burst_active_r
);
    localparam int LIM_LO = `QRT_OSC_LO_CYC - 1;
    localparam int LIM_HI = `QRT_OSC_HI_CYC - 1;
    logic [13:0] per_r;
    logic [13:0] off_r;
    logic gate_d_r;
    logic blk_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // spans since last turn-on and turn-off; saturate so long idles never wrap
    always @(posedge clk) begin
        gate_d_r <= gate_on_r;
        if (!reset_n) begin
            per_r <= 14'h3fff;
            off_r <= 14'h3fff;
            blk_r <= 1'b1;
        end else begin
            per_r <= (gate_on_r && !gate_d_r) ? 14'h1 : per_r + {13'h0, per_r != 14'h3fff};
            off_r <= (!gate_on_r && gate_d_r) ? 14'h1 : off_r + {13'h0, off_r != 14'h3fff};
            if (!gate_on_r && gate_d_r) begin
                blk_r <= blank_long_r; // selection in force at this turn-off
            end
        end
    end
    a_reset_gate_low: assert property ($rose(reset_n) |-> !gate_on_r)
        else $error("gate high right after reset");
    a_stop_gate_off: assert property (supply_below_stop_level && gate_on_r |-> ##[1:5] !gate_on_r)
        else $error("gate stayed on below stop level");
    a_charge_excl_gate: assert property (charge_enable_r |-> !gate_on_r)
        else $error("charging while switching");
    a_osc_spacing: assert property ($rose(gate_on_r) |-> per_r >= (high_rate_variant ? LIM_HI : LIM_LO))
        else $error("turn-on before oscillator period");
    a_blank_holds: assert property ($rose(gate_on_r) |->
        off_r >= (blk_r ? `QRT_BLANK_LONG_CYC : `QRT_BLANK_SHORT_CYC) + 8)
        else $error("turn-on inside blanking");
    a_strobe_delay: assert property ($rose(sense_strobe_r) |-> !gate_on_r && off_r >= 99 && off_r <= 102)
        else $error("sample window misplaced");
    a_strobe_width: assert property ($rose(sense_strobe_r) |-> sense_strobe_r[*8] ##[10:14] !sense_strobe_r)
        else $error("sample window width wrong");
    a_blank_select: assert property ($fell(sense_strobe_r) &&
        demag_above_compare_level == $past(demag_above_compare_level, 30) |->
        ##[0:2] (blank_long_r != demag_above_compare_level))
        else $error("blanking choice wrong");
    a_peak_ends_on: assert property (peak_current_reached && gate_on_r |-> ##[1:5] !gate_on_r)
        else $error("on-time outlived peak current");
    a_burst_quiet: assert property (burst_active_r |-> !$rose(gate_on_r))
        else $error("turn-on in burst pause");
    // main scenarios reached
    c_long_blank: cover property ($rose(gate_on_r) && blk_r);
    c_sampled: cover property ($fell(sense_strobe_r));
    c_burst: cover property (burst_active_r);
endmodule // qrt_checker
`default_nettype wire

// *** dv/qrt_turn_on_bench.sv ***
// self-checking bench for the turn-on timing block
`timescale 1ns/10ps
`default_nettype none
`include "qrt_consts.vh"
module qrt_turn_on_bench;
    logic clk, reset_n, high_rate_variant, supply_above_start_level, supply_below_stop_level;
    logic supply_below_restart_level, drain_above_start_level, fault_event, burst_request;
    logic demag_above_arm_level, demag_above_trigger_level, demag_above_compare_level;
    logic peak_current_reached, gate_on_r, charge_enable_r, charge_reduced_r;
    logic sense_strobe_r, blank_long_r, burst_active_r, arm_en, stuck_hi, compare_hi;
    logic [11:0] on_cyc;
    int error_cnt = 0;
    int samples_checked = 0;
    int per, off;
    // device and far side
    qrt_turn_on u_qrt_turn_on (.clk, .reset_n, .high_rate_variant, .supply_above_start_level,
        .supply_below_stop_level, .supply_below_restart_level, .drain_above_start_level,
        .fault_event, .burst_request, .demag_above_arm_level, .demag_above_trigger_level,
        .demag_above_compare_level, .peak_current_reached, .gate_on_r, .charge_enable_r,
        .charge_reduced_r, .sense_strobe_r, .blank_long_r, .burst_active_r);
    qrt_aux_model u_qrt_aux_model (.clk, .gate_on_r, .arm_en, .stuck_hi, .compare_hi, .on_cyc,
        .demag_above_arm_level, .demag_above_trigger_level, .demag_above_compare_level,
        .peak_current_reached);
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: level %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic check_range(input int v, input int lo, input int hi);
        samples_checked++;
        if (v < lo || v > hi) begin
            error_cnt++;
            $display("Error at %0t: span %0d not in %0d..%0d", $time, v, lo, hi);
        end
    endtask
    // waits for a turn-on, then times rise to rise (per) and the off span (off)
    task automatic cycle_time();
        int n;
        n = 0;
        while (gate_on_r !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
        per = 0;
        while (gate_on_r === 1'b1 && per < 20000) begin @(negedge clk); per++; end
        off = 0;
        while (gate_on_r !== 1'b1 && off < 20000) begin @(negedge clk); off++; end
        per += off;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic t_power_up();
        check_bit(gate_on_r, 1'b0);
        check_bit(blank_long_r, 1'b1);
        repeat (5) @(negedge clk);
        check_bit(charge_enable_r, 1'b1);
        check_bit(charge_reduced_r, 1'b0);
        supply_above_start_level = 1'b1;
        supply_below_stop_level = 1'b0;
        supply_below_restart_level = 1'b0;
        repeat (5) @(negedge clk);
        check_bit(charge_enable_r, 1'b0);
        cycle_time();
        cycle_time();
        check_range(off, `QRT_STARTER_CYC - 5, `QRT_STARTER_CYC + 20);
    endtask
    // armed operation: low rate, high rate, then long blanking past the period
    task automatic t_quasi_res();
        arm_en = 1'b1;
        cycle_time();
        cycle_time();
        check_range(per, `QRT_OSC_LO_CYC, `QRT_OSC_LO_CYC + 84);
        high_rate_variant = 1'b1;
        on_cyc = 12'h64;
        cycle_time();
        cycle_time();
        check_range(per, `QRT_OSC_HI_CYC, `QRT_OSC_HI_CYC + 84);
        compare_hi = 1'b0;
        cycle_time();
        cycle_time();
        cycle_time();
        // the first armed valley after long blanking may lie one and a half ringing periods on
        check_range(off, `QRT_BLANK_LONG_CYC + 8, `QRT_BLANK_LONG_CYC + 112);
    endtask
    task automatic t_floor();
        stuck_hi = 1'b1;
        cycle_time();
        cycle_time();
        check_range(off, `QRT_FLOOR_CYC - 5, `QRT_FLOOR_CYC + 20);
        stuck_hi = 1'b0;
    endtask
    task automatic t_burst();
        int n;
        burst_request = 1'b1;
        repeat (20) @(negedge clk);
        check_bit(burst_active_r, 1'b1);
        // a pulse already under way ends at its peak; only new turn-ons count
        while (gate_on_r === 1'b1) @(negedge clk);
        n = 0;
        repeat (3000) begin @(negedge clk); n += (gate_on_r === 1'b1); end
        check_range(n, 0, 0);
        burst_request = 1'b0;
    endtask
    // fault power-down: wait for restart level, then slow recharge
    task automatic t_fault_restart();
        cycle_time();
        fault_event = 1'b1;
        repeat (4) @(negedge clk);
        fault_event = 1'b0;
        supply_above_start_level = 1'b0;
        repeat (20) @(negedge clk);
        check_bit(gate_on_r, 1'b0);
        check_bit(charge_enable_r, 1'b0);
        supply_below_restart_level = 1'b1;
        repeat (10) @(negedge clk);
        check_bit(charge_enable_r, 1'b1);
        check_bit(charge_reduced_r, 1'b1);
        supply_below_restart_level = 1'b0;
        supply_above_start_level = 1'b1;
        repeat (10) @(negedge clk);
        check_bit(charge_enable_r, 1'b0);
    endtask
    // power-down with the drain low never restarts
    task automatic t_dead();
        drain_above_start_level = 1'b0;
        supply_above_start_level = 1'b0;
        supply_below_stop_level = 1'b1;
        repeat (20) @(negedge clk);
        check_bit(gate_on_r, 1'b0);
        supply_below_restart_level = 1'b1;
        repeat (100) @(negedge clk);
        check_bit(charge_enable_r, 1'b0);
        check_bit(gate_on_r, 1'b0);
        // drain back up: a finished power-down must still not recharge
        drain_above_start_level = 1'b1;
        repeat (20) @(negedge clk);
        check_bit(charge_enable_r, 1'b0);
    endtask
    // main sequence
    initial begin
        {reset_n, high_rate_variant, supply_above_start_level, fault_event, burst_request} = 5'h0;
        {arm_en, stuck_hi} = 2'h0;
        {supply_below_stop_level, supply_below_restart_level, drain_above_start_level, compare_hi} = 4'hf;
        on_cyc = 12'hc8;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        t_power_up();
        t_quasi_res();
        t_floor();
        t_burst();
        t_fault_restart();
        t_dead();
        tally_and_finish();
    end
    // watchdog
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule // qrt_turn_on_bench
bind qrt_turn_on qrt_checker u_qrt_checker (.clk, .reset_n, .high_rate_variant, .supply_below_stop_level,
    .demag_above_compare_level, .peak_current_reached, .gate_on_r, .charge_enable_r, .sense_strobe_r,
    .blank_long_r, .burst_active_r);
`default_nettype wire

// *** verilog/qrt_consts.vh ***
// constants for the quasi-resonant turn-on timing block
`ifndef QRT_CONSTS_VH
`define QRT_CONSTS_VH
`define QRT_CLK_MHZ 100
// frequency-limit oscillator frequencies in kHz (low and high rate variants)
`define QRT_OSC_LO_KHZ 136
`define QRT_OSC_HI_KHZ 225
`define QRT_OSC_LO_CYC ((1000 * `QRT_CLK_MHZ) / `QRT_OSC_LO_KHZ)
`define QRT_OSC_HI_CYC ((1000 * `QRT_CLK_MHZ) / `QRT_OSC_HI_KHZ)
// blanking intervals in ns, least times rounded up
`define QRT_BLANK_SHORT_NS 2500
`define QRT_BLANK_LONG_NS 6300
`define QRT_BLANK_SHORT_CYC ((`QRT_BLANK_SHORT_NS * `QRT_CLK_MHZ + 999) / 1000)
`define QRT_BLANK_LONG_CYC ((`QRT_BLANK_LONG_NS * `QRT_CLK_MHZ + 999) / 1000)
// sense sample delay in ns and window in cycles
`define QRT_STROBE_NS 1000
`define QRT_STROBE_CYC ((`QRT_STROBE_NS * `QRT_CLK_MHZ + 999) / 1000)
`define QRT_STROBE_WIN_CYC 20
// starter and floor frequencies in kHz
`define QRT_STARTER_KHZ 22
`define QRT_FLOOR_KHZ 8
`define QRT_STARTER_CYC ((1000 * `QRT_CLK_MHZ) / `QRT_STARTER_KHZ)
`define QRT_FLOOR_CYC ((1000 * `QRT_CLK_MHZ) / `QRT_FLOOR_KHZ)
// short delay from trigger to gate on
`define QRT_TRIG_DLY_CYC 10
// maximum on-time safety bound in cycles
`define QRT_MAX_ON_CYC 2000
`define QRT_CNT_W 14
`endif

// *** verilog/qrt_sync.v ***
// two-flop synchroniser, one per comparator bit
`timescale 1ns/10ps
`default_nettype none
module qrt_sync #(
    parameter W = 6
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // raw and synchronised levels
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_r;
            reg s2_r;
            // first stage is read only by the second
            always @(posedge clk) begin
                if (!reset_n) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end else begin
                    s1_r <= d[i];
                    s2_r <= s1_r;
                end
            end
            assign q[i] = s2_r;
        end
    endgenerate
endmodule // qrt_sync
`default_nettype wire

// *** verilog/qrt_turn_on.v ***
// quasi-resonant turn-on timing: power sequencing, demag trigger, oscillator, blanking
//
// Overview of operation
// RULE_01: supply below stop level turns the switch off.
// RULE_02: after power-down with drain below start level, inhibit restart.
// RULE_03: with drain above start level, recharge only below restart level.
// RULE_04: charge current reduced after fault, full on normal power-up.
// RULE_05: armed trigger turns switch on after short delay on falling crossing.
// RULE_06: arming only by rising crossing above arm level; unarmed ignores falls.
// RULE_07: demag input ignored during blanking after each turn-off.
// RULE_08: frequency-limit oscillator restarts each turn-on, rate by variant.
// RULE_09: trigger after full oscillator cycle turns on and resyncs oscillator.
// RULE_10: trigger before cycle end ignored; wait for next arm and trigger.
// RULE_11: turn-on inhibit lasts until blanking ends if blanking is longer.
// RULE_12: blanking is short or long.
// RULE_13: short blanking when sample above comparison level, long otherwise.
// RULE_14: blanking select sampled in the overvoltage strobe window.
// RULE_15: unarmed sense voltage gives fixed starter frequency switching.
// RULE_16: once armed, starter stops and turn-on follows demag detection.
// RULE_17: sense permanently above arm level, no trigger: switch at floor frequency.
// RULE_18: extremely light load leaves valley skipping for burst mode.
// RULE_19: at supply start level switching begins, charge source off.
// RULE_20: in undervoltage lockout the gate is held low.
// RULE_21: sense sampled in short window a strobe delay after turn-off.
// RULE_22: peak-current comparator ends on-time, starts blanking and strobe timer.
// RULE_23: comparator inputs synchronised; arm state cleared at each turn-on.
`timescale 1ns/10ps
`default_nettype none
`include "qrt_consts.vh"
module qrt_turn_on (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // product variant: 1 selects the high oscillator rate
    input wire high_rate_variant,
    // supply and drain comparators
    input wire supply_above_start_level,
    input wire supply_below_stop_level,
    input wire supply_below_restart_level,
    input wire drain_above_start_level,
    // fault request from protections, and burst-mode request from feedback
    input wire fault_event,
    input wire burst_request,
    // demag sense comparators and peak current comparator
    input wire demag_above_arm_level,
    input wire demag_above_trigger_level,
    input wire demag_above_compare_level,
    input wire peak_current_reached,
    // outputs
    output reg gate_on_r,
    output reg charge_enable_r,
    output reg charge_reduced_r,
    output reg sense_strobe_r,
    output reg blank_long_r,
    output reg burst_active_r
);
    // power states
    localparam [3:0] ST_CHARGE = 4'b0001;
    localparam [3:0] ST_RUN = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_DEAD = 4'b1000;

    // timing counts as 32-bit copies of the macros, then cut to counter width on purpose;
    // every count fits in the counter, the floor period being the largest
    localparam [31:0] OSC_LO_32 = `QRT_OSC_LO_CYC;
    localparam [31:0] OSC_HI_32 = `QRT_OSC_HI_CYC;
    localparam [31:0] BLANK_SHORT_32 = `QRT_BLANK_SHORT_CYC;
    localparam [31:0] BLANK_LONG_32 = `QRT_BLANK_LONG_CYC;
    localparam [31:0] STROBE_32 = `QRT_STROBE_CYC;
    localparam [31:0] STROBE_WIN_32 = `QRT_STROBE_WIN_CYC;
    localparam [31:0] STARTER_32 = `QRT_STARTER_CYC;
    localparam [31:0] FLOOR_32 = `QRT_FLOOR_CYC;
    localparam [31:0] TRIG_DLY_32 = `QRT_TRIG_DLY_CYC;
    localparam [31:0] MAX_ON_32 = `QRT_MAX_ON_CYC;
    localparam [`QRT_CNT_W-1:0] OSC_LO_LEN = OSC_LO_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] OSC_HI_LEN = OSC_HI_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] BLANK_SHORT_LEN = BLANK_SHORT_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] BLANK_LONG_LEN = BLANK_LONG_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] STROBE_LEN = STROBE_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] STROBE_WIN_LEN = STROBE_WIN_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] STARTER_LEN = STARTER_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] FLOOR_LEN = FLOOR_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] TRIG_DLY_LEN = TRIG_DLY_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] MAX_ON_LEN = MAX_ON_32[`QRT_CNT_W-1:0];
    localparam [`QRT_CNT_W-1:0] CNT_ONE = {{(`QRT_CNT_W-1){1'b0}}, 1'b1};

    wire [7:0] sync_q;
    wire start_s;
    wire drain_s;
    wire arm_s;
    wire trig_s;
    wire cmp_s;
    wire peak_s;
    wire stop_s;
    wire restart_s;

    reg [3:0] pstate_r;
    reg [3:0] pstate_nxt;
    reg fault_seen_r;
    reg arm_prev_r;
    reg trig_prev_r;
    reg armed_r;
    reg ever_armed_r;
    reg [`QRT_CNT_W-1:0] osc_cnt_r;
    reg osc_done_r;
    reg [`QRT_CNT_W-1:0] blank_cnt_r;
    reg [`QRT_CNT_W-1:0] strobe_cnt_r;
    reg strobe_pend_r;
    reg [`QRT_CNT_W-1:0] win_cnt_r;
    reg [`QRT_CNT_W-1:0] off_cnt_r;
    reg [`QRT_CNT_W-1:0] on_cnt_r;
    reg [`QRT_CNT_W-1:0] dly_cnt_r;
    reg dly_pend_r;

    wire [`QRT_CNT_W-1:0] osc_limit;
    wire [`QRT_CNT_W-1:0] blank_len;
    wire running;
    wire blanking;
    wire rise_arm;
    wire fall_trig;
    wire turn_off;
    wire starter_due;
    wire floor_due;
    wire turn_on;

    // synchronise every comparator before any edge detection; the supply levels
    // share the same latency so start and stop never disagree for a cycle
    qrt_sync #(
        .W(8)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d({supply_above_start_level, drain_above_start_level, demag_above_arm_level,
            demag_above_trigger_level, demag_above_compare_level, peak_current_reached,
            supply_below_stop_level, supply_below_restart_level}),
        .q(sync_q)
    ); // RULE_23
    assign arm_s = sync_q[5];
    assign trig_s = sync_q[4];
    assign cmp_s = sync_q[3];
    assign peak_s = sync_q[2];
    assign stop_s = sync_q[1];
    assign restart_s = sync_q[0];
    assign start_s = sync_q[7];
    assign drain_s = sync_q[6];

    // oscillator period chosen by variant
    assign osc_limit = high_rate_variant ? OSC_HI_LEN : OSC_LO_LEN; // RULE_08
    assign blank_len = blank_long_r ? BLANK_LONG_LEN : BLANK_SHORT_LEN; // RULE_12
    assign running = (pstate_r == ST_RUN) && !burst_active_r;
    assign blanking = blank_cnt_r != {`QRT_CNT_W{1'b0}}; // RULE_07
    // demag edges are only seen outside blanking and while off
    assign rise_arm = !gate_on_r && !blanking && arm_s && !arm_prev_r; // RULE_06
    assign fall_trig = !gate_on_r && !blanking && armed_r && !trig_s && trig_prev_r; // RULE_05
    assign turn_off = gate_on_r && (peak_s || on_cnt_r >= MAX_ON_LEN); // RULE_22
    // starter runs only until the first arm; floor timer covers a stuck-high sense
    assign starter_due = !ever_armed_r && off_cnt_r >= STARTER_LEN; // RULE_15
    assign floor_due = ever_armed_r && off_cnt_r >= FLOOR_LEN; // RULE_17
    assign turn_on = running && !gate_on_r && !blanking && osc_done_r &&
        ((dly_pend_r && dly_cnt_r == {`QRT_CNT_W{1'b0}}) || starter_due || floor_due); // RULE_09 RULE_11

    // power sequencing
    always @* begin
        pstate_nxt = pstate_r;
        case (pstate_r)
            ST_CHARGE: begin
                if (start_s) begin
                    pstate_nxt = ST_RUN; // RULE_19
                end
            end
            ST_RUN: begin
                if (stop_s || fault_event) begin
                    pstate_nxt = drain_s ? ST_WAIT : ST_DEAD; // RULE_01 RULE_02
                end
            end
            ST_WAIT: begin
                if (restart_s) begin
                    pstate_nxt = ST_CHARGE; // RULE_03
                end
            end
            ST_DEAD: begin
                pstate_nxt = ST_DEAD; // RULE_02
            end
            default: begin
                pstate_nxt = ST_CHARGE;
            end
        endcase
    end

    // power state and charge control
    always @(posedge clk) begin
        if (!reset_n) begin
            pstate_r <= ST_CHARGE;
            fault_seen_r <= 1'b0;
            charge_enable_r <= 1'b0;
            charge_reduced_r <= 1'b0;
        end else begin
            pstate_r <= pstate_nxt;
            if (pstate_r == ST_RUN && fault_event) begin
                fault_seen_r <= 1'b1;
            end else if (pstate_r == ST_RUN && !fault_event && stop_s) begin
                fault_seen_r <= 1'b0;
            end
            // charge source only on while charging toward start level
            charge_enable_r <= (pstate_nxt == ST_CHARGE) && drain_s; // RULE_19
            charge_reduced_r <= fault_seen_r; // RULE_04
        end
    end

    // burst mode follows the feedback request at light load
    always @(posedge clk) begin
        if (!reset_n) begin
            burst_active_r <= 1'b0;
        end else begin
            burst_active_r <= burst_request && (pstate_r == ST_RUN); // RULE_18
        end
    end

    // gate drive, on-time counter
    always @(posedge clk) begin
        if (!reset_n) begin
            gate_on_r <= 1'b0;
            on_cnt_r <= {`QRT_CNT_W{1'b0}};
        end else if (pstate_r != ST_RUN || stop_s) begin
            gate_on_r <= 1'b0; // RULE_01 RULE_20
            on_cnt_r <= {`QRT_CNT_W{1'b0}};
        end else if (turn_off) begin
            gate_on_r <= 1'b0; // RULE_22
            on_cnt_r <= {`QRT_CNT_W{1'b0}};
        end else if (turn_on) begin
            gate_on_r <= 1'b1; // RULE_05
            on_cnt_r <= {`QRT_CNT_W{1'b0}};
        end else if (gate_on_r) begin
            on_cnt_r <= on_cnt_r + 1'b1;
        end
    end

    // arm and trigger edge detection; arm cleared at turn-on
    // a rise inside the trigger delay stalls the countdown by one cycle only
    always @(posedge clk) begin
        if (!reset_n) begin
            arm_prev_r <= 1'b0;
            trig_prev_r <= 1'b0;
            armed_r <= 1'b0;
            ever_armed_r <= 1'b0;
            dly_pend_r <= 1'b0;
            dly_cnt_r <= {`QRT_CNT_W{1'b0}};
        end else begin
            arm_prev_r <= arm_s;
            trig_prev_r <= trig_s;
            if (turn_on || pstate_r != ST_RUN) begin
                armed_r <= 1'b0; // RULE_23
                dly_pend_r <= 1'b0;
                if (pstate_r != ST_RUN) begin
                    ever_armed_r <= 1'b0;
                end
            end else if (fall_trig) begin
                armed_r <= 1'b0;
                // early triggers are dropped; re-arm needed
                if (osc_done_r) begin
                    dly_pend_r <= 1'b1; // RULE_09
                    dly_cnt_r <= TRIG_DLY_LEN;
                end // RULE_10
            end else if (rise_arm) begin
                armed_r <= 1'b1; // RULE_06
                ever_armed_r <= 1'b1; // RULE_16
            end else if (dly_pend_r && dly_cnt_r != {`QRT_CNT_W{1'b0}}) begin
                dly_cnt_r <= dly_cnt_r - 1'b1; // RULE_05
            end
        end
    end

    // frequency-limit oscillator, restarted on every turn-on
    // done stays set until the next turn-on, so a late valley is never lost
    always @(posedge clk) begin
        if (!reset_n) begin
            osc_cnt_r <= {`QRT_CNT_W{1'b0}};
            osc_done_r <= 1'b0;
        end else if (turn_on) begin
            osc_cnt_r <= {`QRT_CNT_W{1'b0}}; // RULE_08
            osc_done_r <= 1'b0;
        end else if (osc_cnt_r >= osc_limit - 1'b1) begin
            osc_done_r <= 1'b1; // RULE_09
        end else begin
            osc_cnt_r <= osc_cnt_r + 1'b1;
        end
    end

    // off-time counter for starter and floor fallback
    always @(posedge clk) begin
        if (!reset_n) begin
            off_cnt_r <= {`QRT_CNT_W{1'b0}};
        end else if (turn_on || gate_on_r) begin
            off_cnt_r <= {`QRT_CNT_W{1'b0}};
        end else if (off_cnt_r != {`QRT_CNT_W{1'b1}}) begin
            off_cnt_r <= off_cnt_r + 1'b1;
        end
    end

    // blanking timer started by each peak-current or maximum on-time turn-off
    always @(posedge clk) begin
        if (!reset_n) begin
            blank_cnt_r <= {`QRT_CNT_W{1'b0}};
        end else if (turn_off) begin
            blank_cnt_r <= blank_len; // RULE_07 RULE_22
        end else if (blanking) begin
            blank_cnt_r <= blank_cnt_r - 1'b1; // RULE_11
        end
    end

    // strobe timer: delay then sample window; selects next blanking length
    always @(posedge clk) begin
        if (!reset_n) begin
            strobe_cnt_r <= {`QRT_CNT_W{1'b0}};
            strobe_pend_r <= 1'b0;
            win_cnt_r <= {`QRT_CNT_W{1'b0}};
            sense_strobe_r <= 1'b0;
            blank_long_r <= 1'b1; // long blanking until the first sample
        end else if (turn_off) begin
            strobe_cnt_r <= STROBE_LEN; // RULE_21
            strobe_pend_r <= 1'b1;
            sense_strobe_r <= 1'b0;
        end else if (strobe_pend_r) begin
            if (strobe_cnt_r > CNT_ONE) begin
                strobe_cnt_r <= strobe_cnt_r - 1'b1;
            end else begin
                strobe_pend_r <= 1'b0;
                sense_strobe_r <= 1'b1; // RULE_14
                win_cnt_r <= STROBE_WIN_LEN;
            end
        end else if (sense_strobe_r) begin
            // one decision per window taken at its end
            if (win_cnt_r > CNT_ONE) begin
                win_cnt_r <= win_cnt_r - 1'b1;
            end else begin
                sense_strobe_r <= 1'b0;
                blank_long_r <= !cmp_s; // RULE_13
            end
        end
    end
endmodule // qrt_turn_on
`default_nettype wire
